/* File: irqrt_router.sv */
/*
 * irqrt_router: synchronises the interrupt inputs, detects edges and levels
 * per redirection entry, picks one pending entry at a time for the message
 * engine, and routes the dual-role last input to the open-drain pass-through.
 * assumes: redirection entry contents arrive as ports; message engine gives
 * a ready handshake; inputs may be asynchronous to clk_in.
 */
// Functional notes
// RULE1 - each input pin n feeds redirection entry n, for pins 0 to 23.
// RULE2 - entry 23 unmasked: input 23 delivered as an ordinary interrupt message.
// RULE3 - entry 23 masked: input 23 level passed to open-drain pass-through output.
// RULE4 - entry 23 unmasked: deliver programmed message, never drive pass-through output.
// RULE5 - inputs 16 to 19 delivered with the vector programmed in their entry.
// RULE6 - every input synchronised to the clock before edge or level detection.
`timescale 1ns/1ns
module irqrt_router
  import irqrt_pkg::*;
#(
  parameter int unsigned NUM_INPUTS = IRQRT_NUM_INPUTS
) (
  input  wire logic                               clk_in,
  input  wire logic                               srst_in,
  input  wire logic                               ce_in,
  input  wire logic [NUM_INPUTS-1:0]              irq_in,
  input  wire irqrt_entry_cfg_t [NUM_INPUTS-1:0]  entry_cfg_in,
  input  wire logic                               msg_ready_in,
  output logic                                    msg_valid_out,
  output irqrt_msg_t                              msg_out,
  output logic                                    sysmgmt_passthrough_out_n,
  output logic                                    sysmgmt_passthrough_oe_out
);
  // ****************************************************************
  // input synchroniser and edge history
  // ****************************************************************
  logic [NUM_INPUTS-1:0] sync1_q, sync1_d;
  logic [NUM_INPUTS-1:0] sync2_q, sync2_d;
  logic [NUM_INPUTS-1:0] hist_q,  hist_d;
  logic [NUM_INPUTS-1:0] pend_q,  pend_d;
  logic [NUM_INPUTS-1:0] asserted;
  logic [NUM_INPUTS-1:0] grant;
  logic                  launch;
  logic [4:0]            sel;
  logic                  any_pend;

  // two stages, first stage read only by the second
  always_comb begin
    sync1_d = irq_in;   // RULE6
    sync2_d = sync1_q;  // RULE6
    hist_d  = sync2_q;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
      hist_q  <= '0;
    end else if (ce_in) begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      hist_q  <= hist_d;
    end
  end

  // ****************************************************************
  // per-entry detection, pin n drives entry n
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_entry
      logic prev_asserted;
      // polarity applied after synchronisation
      assign asserted[gi]  = sync2_q[gi] ^ entry_cfg_in[gi].active_low;  // RULE1
      assign prev_asserted = hist_q[gi] ^ entry_cfg_in[gi].active_low;
      // new edge wins over the grant that clears it in the same cycle
      always_comb begin
        if (entry_cfg_in[gi].mask) begin
          pend_d[gi] = 1'b0;  // RULE2
        end else if (entry_cfg_in[gi].level_trig) begin
          pend_d[gi] = asserted[gi];
        end else begin
          pend_d[gi] = (asserted[gi] & ~prev_asserted) | (pend_q[gi] & ~grant[gi]);
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pend_q <= '0;
    end else if (ce_in) begin
      pend_q <= pend_d;
    end
  end

  // ****************************************************************
  // selection of the lowest pending entry
  // ****************************************************************
  always_comb begin
    sel      = 5'h00;
    any_pend = 1'b0;
    for (int i = NUM_INPUTS - 1; i >= 0; i--) begin
      if (pend_q[i] && !entry_cfg_in[i].mask) begin
        sel      = 5'(i);
        any_pend = 1'b1;
      end
    end
    launch = ce_in && any_pend && (!msg_valid_out || msg_ready_in);
    grant  = '0;
    if (launch) begin
      grant[sel] = 1'b1;
    end
  end

  // ****************************************************************
  // message register toward the bus engine
  // ****************************************************************
  logic       msg_valid_d;
  irqrt_msg_t msg_d;

  always_comb begin
    msg_valid_d = msg_valid_out;
    msg_d       = msg_out;
    if (launch) begin
      msg_valid_d         = 1'b1;
      msg_d.entry         = sel;                              // RULE1
      msg_d.vector        = entry_cfg_in[sel].vector;         // RULE5
      msg_d.delivery_mode = entry_cfg_in[sel].delivery_mode;  // RULE4
    end else if (msg_ready_in) begin
      msg_valid_d = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      msg_valid_out <= 1'b0;
      msg_out       <= '{entry: 5'h00, delivery_mode: IRQRT_MODE_RST, vector: IRQRT_VECTOR_RST};
    end else if (ce_in) begin
      msg_valid_out <= msg_valid_d;
      msg_out       <= msg_d;
    end
  end

  // ****************************************************************
  // dual-role last input: open-drain pass-through
  // ****************************************************************
  logic pass_n_d, pass_oe_d;
  logic dual_mask;
  assign dual_mask = entry_cfg_in[IRQRT_DUAL_ENTRY].mask;

  // pull low only while masked and the request is low
  always_comb begin
    pass_oe_d = dual_mask && !sync2_q[IRQRT_DUAL_ENTRY];  // RULE3 RULE4
    pass_n_d  = !pass_oe_d;                               // RULE3
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sysmgmt_passthrough_out_n  <= 1'b1;
      sysmgmt_passthrough_oe_out <= 1'b0;
    end else if (ce_in) begin
      sysmgmt_passthrough_out_n  <= pass_n_d;
      sysmgmt_passthrough_oe_out <= pass_oe_d;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_two_enabled;
    ce_in ##1 ce_in;
  endsequence

  property p_sync;
    @(posedge clk_in) disable iff (srst_in)
      s_two_enabled |=> (sync2_q == $past(irq_in, IRQRT_SYNC_STAGES));
  endproperty
  a_sync: assert property (p_sync) else $error("input not synchronised in two stages");  // RULE6

  property p_route;
    @(posedge clk_in) disable iff (srst_in)
      launch |=> msg_valid_out && (msg_out.entry == $past(sel)) && $past(pend_q[sel]);
  endproperty
  a_route: assert property (p_route) else $error("message entry not the pending pin");  // RULE1

  property p_dual_unmasked;
    @(posedge clk_in) disable iff (srst_in)
      (launch && sel == IRQRT_DUAL_ENTRY) |-> !dual_mask;
  endproperty
  a_dual_unmasked: assert property (p_dual_unmasked) else $error("masked last input sent as message");  // RULE2

  property p_pass_drive;
    @(posedge clk_in) disable iff (srst_in)
      (ce_in && dual_mask && !sync2_q[IRQRT_DUAL_ENTRY]) |=>
        sysmgmt_passthrough_oe_out && !sysmgmt_passthrough_out_n;
  endproperty
  a_pass_drive: assert property (p_pass_drive) else $error("pass-through not driven low");  // RULE3

  property p_pass_quiet;
    @(posedge clk_in) disable iff (srst_in)
      (ce_in && !dual_mask) |=> !sysmgmt_passthrough_oe_out;
  endproperty
  a_pass_quiet: assert property (p_pass_quiet) else $error("pass-through driven while unmasked");  // RULE4

  property p_vector;
    @(posedge clk_in) disable iff (srst_in)
      (launch && sel >= IRQRT_SHARED_LO && sel <= IRQRT_SHARED_HI) |=>
        msg_out.vector == $past(entry_cfg_in[sel].vector);
  endproperty
  a_vector: assert property (p_vector) else $error("shared input vector not from its entry");  // RULE5

  property p_hold;
    @(posedge clk_in) disable iff (srst_in)
      (msg_valid_out && !msg_ready_in) |=> msg_valid_out && $stable(msg_out);
  endproperty
  a_hold: assert property (p_hold) else $error("message changed while stalled");  // RULE4
endmodule : irqrt_router

/* File: irqrt_pkg.sv */
/*
 * irqrt_pkg: constants and types for the interrupt input routing front end.
 * assumes: one clock domain, synchronous active-high reset, 24 interrupt inputs.
 */
package irqrt_pkg;
  // ****************************************************************
  // sizes and indices
  // ****************************************************************
  localparam int unsigned IRQRT_NUM_INPUTS  = 24;
  localparam int unsigned IRQRT_ENTRY_W     = 5;
  localparam logic [4:0]  IRQRT_DUAL_ENTRY  = 5'h17;  // last input, dual role
  localparam logic [4:0]  IRQRT_SHARED_LO   = 5'h10;  // shared inputs, first
  localparam logic [4:0]  IRQRT_SHARED_HI   = 5'h13;  // shared inputs, last
  localparam int unsigned IRQRT_SYNC_STAGES = 2;

  // ****************************************************************
  // reset values and delivery modes
  // ****************************************************************
  localparam logic [7:0] IRQRT_VECTOR_RST = 8'h00;
  localparam logic [2:0] IRQRT_MODE_RST   = 3'h0;
  localparam logic [2:0] IRQRT_MODE_SMI   = 3'h2;  // system-management delivery

  // ****************************************************************
  // per-entry configuration, supplied by the redirection table
  // ****************************************************************
  typedef struct packed {
    logic       mask;          // 1 = entry masked
    logic       level_trig;    // 1 = level, 0 = edge
    logic       active_low;    // 1 = input asserted when low
    logic [2:0] delivery_mode; // message type
    logic [7:0] vector;        // interrupt vector
  } irqrt_entry_cfg_t;

  // message handed to the bus message engine
  typedef struct packed {
    logic [4:0] entry;
    logic [2:0] delivery_mode;
    logic [7:0] vector;
  } irqrt_msg_t;
endpackage : irqrt_pkg

/* File: irqrt_engine_model.sv */
/*
 * irqrt_engine_model: stand-in for the bus message engine, plus the
 * pull-up on the open-drain pass-through line.
 * assumes: stall_in is driven just after rising edges of clk_in.
 */
`timescale 1ns/1ns
module irqrt_engine_model (
  input  wire logic clk_in,
  input  wire logic stall_in,
  input  wire logic oe_in,
  input  wire logic data_n_in,
  output logic      ready_out,
  output wire logic line_n_out
);
  // ready follows the stall request one edge later, changed after the edge
  initial ready_out = 1'b0;
  always @(posedge clk_in) begin
    ready_out <= #1 ~stall_in;
  end
  // the line is pulled up unless the block drives it
  assign line_n_out = oe_in ? data_n_in : 1'b1;
endmodule : irqrt_engine_model

/* File: irqrt_router_tb.sv */
/*
 * irqrt_router_tb: self-checking bench for the interrupt input router.
 * assumes: engine model supplies ready and the pass-through pull-up.
 */
`timescale 1ns/1ns
module irqrt_router_tb
  import irqrt_pkg::*;
;
  logic                          clk_in;
  logic                          srst_in;
  logic                          stall;
  logic                          ce;
  logic [23:0]                   irq_in;
  irqrt_entry_cfg_t [23:0]       cfg;
  logic                          ready;
  logic                          valid;
  irqrt_msg_t                    msg;
  logic                          pt_n;
  logic                          pt_oe;
  logic                          line_n;
  int                            err_total;
  int                            n_tests;

  irqrt_router u_dut (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce), .irq_in(irq_in),
    .entry_cfg_in(cfg), .msg_ready_in(ready), .msg_valid_out(valid), .msg_out(msg),
    .sysmgmt_passthrough_out_n(pt_n), .sysmgmt_passthrough_oe_out(pt_oe));
  irqrt_engine_model u_eng (.clk_in(clk_in), .stall_in(stall), .oe_in(pt_oe),
    .data_n_in(pt_n), .ready_out(ready), .line_n_out(line_n));

  // clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk

  task end_sim;
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  // one edge pulse on pin n, driven just after rising edges
  task pulse(input int n);
    @(posedge clk_in); #1 irq_in[n] = 1'b1;
    @(posedge clk_in); #1 irq_in[n] = 1'b0;
  endtask : pulse

  task wait_msg(input logic [4:0] e, input logic [7:0] v, input logic [2:0] m);
    int i;
    i = 0;
    @(negedge clk_in);
    while (valid !== 1'b1 && i < 20) begin
      @(negedge clk_in);
      i++;
    end
    chk(valid === 1'b1 && msg === {e, m, v}, "wrong message");
  endtask : wait_msg

  // every pin reaches its own entry with that entry's vector and mode
  task t_route;
    for (int n = 0; n < 24; n++) begin
      pulse(n);
      wait_msg(5'(n), 8'(8'h40 + n), (n == 23) ? IRQRT_MODE_SMI : IRQRT_MODE_RST);
    end
    chk(pt_oe === 1'b0 && line_n === 1'b1, "pass-through driven while unmasked");
  endtask : t_route

  // fixed synchroniser latency, then the message holds while stalled
  task t_sync;
    msg_hold_chk();
  endtask : t_sync

  task msg_hold_chk;
    @(posedge clk_in); #1 irq_in[5] = 1'b1; stall = 1'b1;
    repeat (3) @(posedge clk_in);
    @(negedge clk_in) chk(valid === 1'b0, "message too early");
    @(negedge clk_in) chk(valid === 1'b1 && msg.entry === 5'h05, "message late");
    @(posedge clk_in); #1 irq_in[5] = 1'b0;
    repeat (3) @(negedge clk_in);
    chk(valid === 1'b1 && msg.vector === 8'h45, "message lost while stalled");
    @(posedge clk_in); #1 stall = 1'b0;
    repeat (3) @(negedge clk_in);
    chk(valid === 1'b0, "message not taken");
  endtask : msg_hold_chk

  // clock enable low freezes input sampling and a pending message
  task t_freeze;
    @(posedge clk_in); #1 ce = 1'b0; stall = 1'b1; irq_in[7] = 1'b1;
    repeat (5) @(negedge clk_in);
    chk(valid === 1'b0, "input taken while frozen");
    @(posedge clk_in); #1 ce = 1'b1;
    wait_msg(5'h07, 8'h47, IRQRT_MODE_RST);
    @(posedge clk_in); #1 ce = 1'b0; stall = 1'b0; irq_in[7] = 1'b0;
    repeat (4) @(negedge clk_in);
    chk(valid === 1'b1 && msg.entry === 5'h07, "message lost while frozen");
    @(posedge clk_in); #1 ce = 1'b1;
    repeat (2) @(negedge clk_in);
    chk(valid === 1'b0, "message not taken after freeze");
  endtask : t_freeze

  // active-low level entry keeps requesting while its pin is low
  task t_level;
    @(posedge clk_in); #1 cfg[9].level_trig = 1'b1; cfg[9].active_low = 1'b1;
    wait_msg(5'h09, 8'h49, IRQRT_MODE_RST);
    @(posedge clk_in); #1 irq_in[9] = 1'b1;
    repeat (2) @(negedge clk_in);
    chk(valid === 1'b1 && msg.entry === 5'h09, "level request not repeated");
    repeat (4) @(negedge clk_in);
    chk(valid === 1'b0, "released level still requesting");
    @(posedge clk_in); #1 irq_in[9] = 1'b0; cfg[9].level_trig = 1'b0; cfg[9].active_low = 1'b0;
  endtask : t_level

  // masked entry 23 passes the pin level and sends nothing
  task t_pass;
    @(posedge clk_in); #1 cfg[23].mask = 1'b1;
    repeat (4) @(negedge clk_in);
    chk(pt_oe === 1'b1 && line_n === 1'b0 && valid === 1'b0, "low not passed");
    @(posedge clk_in); #1 irq_in[23] = 1'b1;
    repeat (4) @(negedge clk_in);
    chk(pt_oe === 1'b0 && line_n === 1'b1 && valid === 1'b0, "high not passed");
    @(posedge clk_in); #1 irq_in[23] = 1'b0; cfg[23].mask = 1'b0;
    repeat (4) @(negedge clk_in);
    chk(pt_oe === 1'b0 && line_n === 1'b1 && valid === 1'b0, "driven after unmask");
  endtask : t_pass

  // main sequence
  initial begin
    err_total = 0;
    n_tests = 0;
    srst_in = 1'b1;
    stall = 1'b0;
    ce = 1'b1;
    irq_in = '0;
    for (int n = 0; n < 24; n++) begin
      cfg[n] = '{1'b0, 1'b0, 1'b0, (n == 23) ? IRQRT_MODE_SMI : IRQRT_MODE_RST, 8'(8'h40 + n)};
    end
    repeat (10) @(posedge clk_in);
    #1 srst_in = 1'b0;
    @(negedge clk_in) chk(valid === 1'b0 && pt_oe === 1'b0 && line_n === 1'b1, "reset state");
    t_route();
    t_sync();
    t_freeze();
    t_level();
    t_pass();
    end_sim();
  end

  // watchdog
  initial begin
    #20000;
    err_total++;
    end_sim();
  end
endmodule : irqrt_router_tb
